// File: nvh_host_ctl.sv
// host controller for a 128k x 16 nonvolatile sram-style memory
// assumes the memory sits directly on the pins and that requests come from one master
`timescale 1ns/10ps
module nvh_host_ctl
   import nvh_pkg::*;
   #(parameter int AW = 17,
     parameter int DW = 16,
     parameter int PU_CYCLES = PU_CYC,
     parameter bit HOLD_CE = 1'b1)
   (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [AW-1:0] req_addr_in,
   input wire logic [DW-1:0] req_wdata_in,
   input wire logic [1:0] req_be_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [DW-1:0] rsp_rdata_out,
   output logic ce_n_out,
   output logic we_n_out,
   output logic oe_n_out,
   output logic upper_byte_sel_n_out,
   output logic lower_byte_sel_n_out,
   output logic [AW-1:0] addr_out,
   output logic [DW-1:0] dq_out,
   output logic dq_oe_out,
   input wire logic [DW-1:0] dq_in
   );
   // ************************************************************
   // state
   // ************************************************************
   nvh_state_t st;
   nvh_state_t next_st;
   logic [AW-1:0] addr_q;
   logic [AW-1:0] next_addr_q;
   logic [DW-1:0] wdata_q;
   logic [DW-1:0] next_wdata_q;
   logic [1:0] be_q;
   logic [1:0] next_be_q;
   logic wr_q;
   logic next_wr_q;
   logic page_q;
   logic next_page_q;
   logic ce_low;
   logic next_ce_low;
   logic we_low;
   logic next_we_low;
   logic oe_low;
   logic next_oe_low;
   logic dq_oe;
   logic next_dq_oe;
   logic [1:0] bsel_n;
   logic [1:0] next_bsel_n;
   logic [CE_CNT_W-1:0] ce_cnt;
   logic [CE_CNT_W-1:0] next_ce_cnt;
   logic [DW-1:0] rdata;
   logic [DW-1:0] next_rdata;
   logic rsp_valid;
   logic next_rsp_valid;
   logic keep_ce;
   logic take;

   nvh_tmr_if #(.W(TMR_W)) tmr_bus ();

   nvh_timer #(.W(TMR_W)) u_timer (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .t(tmr_bus.tmr)
   );

   // ************************************************************
   // next-state logic
   // ************************************************************
   // stay selected only while budget leaves room for a worst-case access
   assign keep_ce = HOLD_CE && (ce_cnt < CE_CNT_W'(CE_MAX_CYC - CE_GUARD));
   assign req_ready_out = (st == ST_IDLE) || ((st == ST_END) && keep_ce);
   assign take = req_valid_in && req_ready_out;

   always_comb
   begin
      next_st = st;
      next_addr_q = addr_q;
      next_wdata_q = wdata_q;
      next_be_q = be_q;
      next_wr_q = wr_q;
      next_page_q = page_q;
      next_ce_low = ce_low;
      next_rdata = rdata;
      next_rsp_valid = 1'b0;
      tmr_bus.load = 1'b0;
      tmr_bus.val = '0;
      if (take)
      begin
         next_addr_q = req_addr_in;
         next_wdata_q = req_wdata_in;
         next_be_q = req_be_in;
         next_wr_q = req_write_in;
      end
      case (st)
         ST_BOOT:
         begin
            // memory not usable until power-up delay passes, select held high
            tmr_bus.load = 1'b1;
            tmr_bus.val = TMR_W'(PU_CYCLES);
            next_ce_low = 1'b0;
            next_st = ST_PU;
         end
         ST_PU:
         begin
            if (tmr_bus.done)
            begin
               next_st = ST_IDLE;
            end
         end
         ST_IDLE:
         begin
            if (take)
            begin
               next_page_q = 1'b0;
               next_ce_low = 1'b1;
               next_st = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            // only a follow-on access inside the open row, same word included, earns the short wait
            tmr_bus.load = 1'b1;
            tmr_bus.val = page_q ? TMR_W'(PAGE_CYC) : TMR_W'(ACC_CYC);
            next_st = ST_ACCESS;
         end
         ST_ACCESS:
         begin
            if (tmr_bus.done)
            begin
               if (!wr_q)
               begin
                  next_rdata = dq_in;
                  next_rsp_valid = 1'b1;
               end
               next_st = ST_END;
            end
         end
         ST_END:
         begin
            if (take)
            begin
               // same upper bits keep the row, the memory sees the new address
               next_page_q = (req_addr_in[AW-1:COL_W] == addr_q[AW-1:COL_W]);
               next_st = ST_SETUP;
            end
            else
            begin
               // release select as soon as the burst runs dry
               next_ce_low = 1'b0;
               tmr_bus.load = 1'b1;
               tmr_bus.val = TMR_W'(PC_CYC);
               next_st = ST_PRECH;
            end
         end
         ST_PRECH:
         begin
            if (tmr_bus.done)
            begin
               next_st = ST_IDLE;
            end
         end
         default:
         begin
            next_ce_low = 1'b0;
            next_st = ST_BOOT;
         end
      endcase
      // strobes registered so the pins never glitch
      next_we_low = (next_st == ST_ACCESS) && next_wr_q;
      next_oe_low = ((next_st == ST_SETUP) || (next_st == ST_ACCESS)) && !next_wr_q;
      next_dq_oe = next_wr_q && ((next_st == ST_SETUP) || (next_st == ST_ACCESS)
                   || (next_st == ST_END));
      next_bsel_n = next_ce_low ? ~next_be_q : 2'h3;
      next_ce_cnt = ce_low ? ce_cnt + CE_CNT_W'(1) : '0;
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         st <= ST_BOOT;
         addr_q <= '0;
         wdata_q <= '0;
         be_q <= 2'h0;
         wr_q <= 1'b0;
         page_q <= 1'b0;
         ce_low <= 1'b0;
         we_low <= 1'b0;
         oe_low <= 1'b0;
         dq_oe <= 1'b0;
         bsel_n <= 2'h3;
         ce_cnt <= '0;
         rdata <= '0;
         rsp_valid <= 1'b0;
      end
      else
      begin
         st <= next_st;
         addr_q <= next_addr_q;
         wdata_q <= next_wdata_q;
         be_q <= next_be_q;
         wr_q <= next_wr_q;
         page_q <= next_page_q;
         ce_low <= next_ce_low;
         we_low <= next_we_low;
         oe_low <= next_oe_low;
         dq_oe <= next_dq_oe;
         bsel_n <= next_bsel_n;
         ce_cnt <= next_ce_cnt;
         rdata <= next_rdata;
         rsp_valid <= next_rsp_valid;
      end
   end

   assign ce_n_out = ~ce_low;
   assign we_n_out = ~we_low;
   assign oe_n_out = ~oe_low;
   assign upper_byte_sel_n_out = bsel_n[1];
   assign lower_byte_sel_n_out = bsel_n[0];
   assign addr_out = addr_q;
   assign dq_out = wdata_q;
   assign dq_oe_out = dq_oe;
   assign rsp_valid_out = rsp_valid;
   assign rsp_rdata_out = rdata;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence sel_rises;
      $rose(ce_n_out);
   endsequence
   sequence sel_held_high;
      ce_n_out [*2];
   endsequence

   ce_limit_a: assert property (!ce_n_out |-> ce_cnt < CE_CNT_W'(CE_MAX_CYC))
      else $error("chip select low too long");
   boot_ce_a: assert property ((st == ST_BOOT || st == ST_PU) |-> ce_n_out)
      else $error("chip select low before power-up delay");
   we_in_ce_a: assert property (!we_n_out |-> !ce_n_out && dq_oe_out)
      else $error("write strobe without select or data");
   toggle_ce_a: assert property (!HOLD_CE && st == ST_END |=> ce_n_out)
      else $error("select not toggled per access");
   idle_ce_a: assert property (st == ST_IDLE |-> ce_n_out)
      else $error("select low while idle");
   precharge_a: assert property (sel_rises |-> sel_held_high)
      else $error("precharge shorter than two cycles");
   lane_map_a: assert property (!ce_n_out |->
      {upper_byte_sel_n_out, lower_byte_sel_n_out} == ~be_q)
      else $error("byte selects do not follow enables");
endmodule // nvh_host_ctl

// File: nvh_pkg.sv
// constants, state encoding and cycle counts for the nonvolatile sram host port
// assumes a single 40 MHz clock; every count below is derived from that rate
package nvh_pkg;
   // ************************************************************
   // timing figures as printed
   // ************************************************************
   localparam int CLK_MHZ = 40;
   localparam int T_AA_NS = 110;
   localparam int T_PC_NS = 50;
   localparam int T_CA_MAX_NS = 10000;
   localparam int PAGE_MHZ = 33;
   localparam int T_PU_US = 450;
   // ************************************************************
   // derived cycle counts
   // ************************************************************
   // least times round up, the longest time rounds down
   localparam int ACC_CYC = (T_AA_NS * CLK_MHZ + 999) / 1000;
   localparam int PAGE_CYC = (CLK_MHZ + PAGE_MHZ - 1) / PAGE_MHZ;
   localparam int PC_CYC = (T_PC_NS * CLK_MHZ + 999) / 1000;
   localparam int CE_MAX_CYC = (T_CA_MAX_NS * CLK_MHZ) / 1000;
   localparam int PU_CYC = T_PU_US * CLK_MHZ;
   // worst access plus setup and end cycles, kept as headroom
   localparam int CE_GUARD = ACC_CYC + 3;
   localparam int TMR_W = 15;
   localparam int CE_CNT_W = 10;
   localparam int COL_W = 2;
   // ************************************************************
   // controller states
   // ************************************************************
   typedef enum logic [2:0] {
      ST_BOOT = 3'h0,
      ST_PU = 3'h1,
      ST_IDLE = 3'h2,
      ST_SETUP = 3'h3,
      ST_ACCESS = 3'h4,
      ST_END = 3'h5,
      ST_PRECH = 3'h6
   } nvh_state_t;
endpackage

// File: nvh_tmr_if.sv
// load and done signals between the host controller and its wait timer
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface nvh_tmr_if
   #(parameter int W = 15);
   logic load;
   logic [W-1:0] val;
   logic done;
   modport ctl (output load, output val, input done);
   modport tmr (input load, input val, output done);
endinterface

// File: nvh_timer.sv
// down-counting wait timer; done is high while the count rests at zero
// assumes load is a one-cycle pulse from the controller
`timescale 1ns/10ps
module nvh_timer
   import nvh_pkg::*;
   #(parameter int W = TMR_W)
   (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   nvh_tmr_if.tmr t
   );
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   always_comb
   begin
      next_cnt = cnt;
      if (t.load)
      begin
         next_cnt = t.val;
      end
      else if (cnt != '0)
      begin
         next_cnt = cnt - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         cnt <= '0;
      end
      else
      begin
         cnt <= next_cnt;
      end
   end

   // done never looks at load, so the controller's decode forms no loop through it
   assign t.done = (cnt == '0);
endmodule // nvh_timer

// File: nvh_mem_model.sv
// behavioural model of the 128k x 16 nonvolatile sram on the host pins
// assumes the pins come straight from nvh_host_ctl with no board delay
`timescale 1ns/10ps
module nvh_mem_model
   #(parameter int ACC_NS = 20)
   (
   input wire logic ce_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   input wire logic ub_n_in,
   input wire logic lb_n_in,
   input wire logic [16:0] addr_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out
   );
   // ********************************
   // array and write window
   // ********************************
   logic [15:0] mem [int];
   logic [15:0] cur;
   logic [15:0] rcur;
   logic [15:0] rd;
   logic wr_on = 1'b0;
   always @(negedge we_n_in)
      if (!ce_n_in)
         wr_on = 1'b1;
   // first rising edge of strobe or select ends the write
   always @(posedge we_n_in or posedge ce_n_in)
   begin
      if (wr_on)
      begin
         cur = mem.exists(int'(addr_in)) ? mem[int'(addr_in)] : 16'h0F0F;
         if (!ub_n_in)
            cur[15:8] = wdata_in[15:8];
         if (!lb_n_in)
            cur[7:0] = wdata_in[7:0];
         mem[int'(addr_in)] = cur;
      end
      wr_on = 1'b0;
   end
   // any address change reselects the word, row or column alike
   always @(ce_n_in or oe_n_in or we_n_in or addr_in or ub_n_in or lb_n_in or wr_on)
   begin
      rcur = mem.exists(int'(addr_in)) ? mem[int'(addr_in)] : 16'h0F0F;
      rd = ~rcur;
      if (!ce_n_in && !oe_n_in && we_n_in)
      begin
         if (!ub_n_in)
            rd[15:8] = rcur[15:8];
         if (!lb_n_in)
            rd[7:0] = rcur[7:0];
      end
   end
   // undriven lanes show the inverse so a stale value cannot pass
   assign #(ACC_NS) rdata_out = rd;
endmodule // nvh_mem_model

// File: tb_top.sv
// self-checking bench for nvh_host_ctl against a behavioural memory
// assumes the design's power-up wait is shortened through PU_CYCLES
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
   $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
   localparam int PU = 20;
   logic ref_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic req_valid_in = 1'b0;
   logic req_write_in = 1'b0;
   logic [16:0] req_addr_in = 17'h0;
   logic [15:0] req_wdata_in = 16'h0;
   logic [1:0] req_be_in = 2'h3;
   logic req_ready_out, rsp_valid_out, ce_n_out, we_n_out, oe_n_out, ub_n, lb_n, dq_oe_out;
   logic [15:0] rsp_rdata_out, dq_out, dq_in;
   logic [16:0] addr_out;
   logic prev_ce = 1'b1;
   logic prev_tg = 1'b1;
   logic tg_valid = 1'b0;
   logic tg_ready, tg_rsp_v, tg_ce_n, tg_we_n, tg_oe_n, tg_ub, tg_lb, tg_dq_oe;
   logic [15:0] tg_rdata, tg_dq, tg_dq_in;
   logic [16:0] tg_addr;
   int fails = 0, cmp_count = 0, cyc = 0, ce_lo = 0, ce_rise = 0, tg_rise = 0;
   int takes[$];
   int lats[$];
   logic [15:0] rdq[$];
   always #12.5 ref_clk_in = ~ref_clk_in;
   nvh_host_ctl #(.PU_CYCLES(PU)) dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
      .req_wdata_in(req_wdata_in), .req_be_in(req_be_in), .req_ready_out(req_ready_out),
      .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .ce_n_out(ce_n_out),
      .we_n_out(we_n_out), .oe_n_out(oe_n_out), .upper_byte_sel_n_out(ub_n),
      .lower_byte_sel_n_out(lb_n), .addr_out(addr_out), .dq_out(dq_out),
      .dq_oe_out(dq_oe_out), .dq_in(dq_in));
   nvh_mem_model mem (.ce_n_in(ce_n_out), .we_n_in(we_n_out), .oe_n_in(oe_n_out),
      .ub_n_in(ub_n), .lb_n_in(lb_n), .addr_in(addr_out), .wdata_in(dq_out),
      .rdata_out(dq_in));
   // second controller in toggle mode, sharing the request fields
   nvh_host_ctl #(.PU_CYCLES(PU), .HOLD_CE(1'b0)) dut_tog (.ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in), .req_valid_in(tg_valid), .req_write_in(req_write_in),
      .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_be_in(req_be_in),
      .req_ready_out(tg_ready), .rsp_valid_out(tg_rsp_v), .rsp_rdata_out(tg_rdata),
      .ce_n_out(tg_ce_n), .we_n_out(tg_we_n), .oe_n_out(tg_oe_n),
      .upper_byte_sel_n_out(tg_ub), .lower_byte_sel_n_out(tg_lb), .addr_out(tg_addr),
      .dq_out(tg_dq), .dq_oe_out(tg_dq_oe), .dq_in(tg_dq_in));
   nvh_mem_model mem_tog (.ce_n_in(tg_ce_n), .we_n_in(tg_we_n), .oe_n_in(tg_oe_n),
      .ub_n_in(tg_ub), .lb_n_in(tg_lb), .addr_in(tg_addr), .wdata_in(tg_dq),
      .rdata_out(tg_dq_in));
   // ********************************
   // monitor and closing
   // ********************************
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (req_valid_in && req_ready_out === 1'b1 && !req_write_in)
         takes.push_back(cyc);
      if (rsp_valid_out === 1'b1)
      begin
         lats.push_back(cyc - takes.pop_front());
         rdq.push_back(rsp_rdata_out);
      end
      ce_lo = (ce_n_out === 1'b0) ? ce_lo + 1 : 0;
      `CHK(ce_lo < 400, 1'b1)
      if (ce_n_out === 1'b1 && prev_ce === 1'b0)
         ce_rise++;
      prev_ce = ce_n_out;
      if (tg_ce_n === 1'b1 && prev_tg === 1'b0)
         tg_rise++;
      prev_tg = tg_ce_n;
      if (cyc == 20000)
      begin
         fails++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // request stays up until taken, then waits for the next change
   task automatic issue(input logic w, input logic [16:0] a, input logic [15:0] d,
      input logic [1:0] be);
      @(negedge ref_clk_in);
      req_valid_in = 1'b1;
      req_write_in = w;
      req_addr_in = a;
      req_wdata_in = d;
      req_be_in = be;
      // ready comes from registered state only, so it is settled at the falling edge
      while (req_ready_out !== 1'b1)
         @(negedge ref_clk_in);
      @(posedge ref_clk_in);
   endtask
   task automatic quiet;
      @(negedge ref_clk_in);
      req_valid_in = 1'b0;
      repeat (12) @(posedge ref_clk_in);
   endtask
   // ********************************
   // scenarios
   // ********************************
   task automatic t_reset;
      repeat (3) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      rst_b_in = 1'b1;
      repeat (PU)
      begin
         @(negedge ref_clk_in);
         `CHK(ce_n_out, 1'b1)
         `CHK(req_ready_out, 1'b0)
      end
   endtask
   task automatic t_lanes;
      logic [15:0] rv;
      rdq.delete();
      issue(1'b1, 17'h00123, 16'hABCD, 2'h3);
      issue(1'b1, 17'h00123, 16'h1234, 2'h1);
      issue(1'b1, 17'h00123, 16'h5600, 2'h2);
      issue(1'b1, 17'h00123, 16'hFFFF, 2'h0);
      issue(1'b0, 17'h00123, 16'h0000, 2'h3);
      issue(1'b0, 17'h00123, 16'h0000, 2'h2);
      quiet();
      rv = rdq.pop_front();
      `CHK(rv, 16'h5634)
      rv = rdq.pop_front();
      // the model shows the inverse on an unselected lane
      `CHK(rv, 16'h56CB)
   endtask
   task automatic t_page;
      int offs[5] = '{0, 1, 3, 4, 2};
      int el[5] = '{8, 5, 5, 8, 8};
      int r0;
      int lat;
      logic [15:0] rv;
      lats.delete();
      rdq.delete();
      r0 = ce_rise;
      for (int i = 0; i < 5; i++)
         issue(1'b1, 17'h00A80 + 17'(i), 16'hC000 + 16'(i), 2'h3);
      for (int i = 0; i < 5; i++)
         issue(1'b0, 17'h00A80 + 17'(offs[i]), 16'h0000, 2'h3);
      quiet();
      // select rises once only, when the burst runs dry
      `CHK(ce_rise, r0 + 1)
      for (int i = 0; i < 5; i++)
      begin
         lat = lats.pop_front();
         rv = rdq.pop_front();
         `CHK(lat, el[i])
         `CHK(rv, 16'hC000 + 16'(offs[i]))
      end
   endtask
   task automatic t_toggle;
      int r0;
      r0 = tg_rise;
      @(negedge ref_clk_in);
      tg_valid = 1'b1;
      req_write_in = 1'b1;
      req_addr_in = 17'h00A80;
      req_wdata_in = 16'h1357;
      req_be_in = 2'h3;
      while (tg_ready !== 1'b1)
         @(negedge ref_clk_in);
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      req_write_in = 1'b0;
      while (tg_ready !== 1'b1)
         @(negedge ref_clk_in);
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      tg_valid = 1'b0;
      while (tg_rsp_v !== 1'b1)
         @(negedge ref_clk_in);
      `CHK(tg_rdata, 16'h1357)
      repeat (6) @(negedge ref_clk_in);
      // one rise after the write and one after the read
      `CHK(tg_rise - r0, 2)
   endtask
   task automatic t_burst;
      int r0;
      rdq.delete();
      r0 = ce_rise;
      for (int i = 0; i < 120; i++)
         issue(1'b0, 17'h00A80 + 17'(i % 4), 16'h0000, 2'h3);
      quiet();
      `CHK(ce_rise - r0 >= 2, 1'b1)
      `CHK(rdq.size(), 120)
      `CHK(ce_n_out, 1'b1)
   endtask
   initial
   begin
      t_reset();
      t_lanes();
      t_page();
      t_burst();
      t_toggle();
      wrap_up();
   end
endmodule // tb_top
